/* File: design/mii_tx_pkg.sv */
/*
 * Shared constants and types for the MII/RMII transmit clocking block.
 * Assumes a 50 MHz REF_CLK for RMII and MII-DCE and a 20 MHz mclk.
 */
package mii_tx_pkg;

    // Link interface modes
    typedef enum logic [1:0]
    {
        MODE_RMII    = 2'b00,
        MODE_MII_DCE = 2'b01,
        MODE_MII_DTE = 2'b10
    } link_mode_t;

    // Transmit sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_SEND  = 2'b01,
        ST_DRAIN = 2'b10
    } tx_state_t;

    // Clock rates in kHz
    localparam int unsigned MCLK_KHZ       = 20000;
    localparam int unsigned REF_CLK_KHZ    = 50000;
    localparam int unsigned TXCLK_100_KHZ  = 25000;
    localparam int unsigned TXCLK_10_KHZ   = 2500;
    localparam int unsigned RMII_10_KHZ    = 5000;
    localparam int unsigned REFO_KHZ_DFLT  = 10000;

    // Divider width and half periods in REF_CLK cycles
    localparam int          DIV_W        = 4;
    localparam logic [DIV_W-1:0] HALF_MII_100 =
        DIV_W'(REF_CLK_KHZ / (2 * TXCLK_100_KHZ));
    localparam logic [DIV_W-1:0] HALF_MII_10 =
        DIV_W'(REF_CLK_KHZ / (2 * TXCLK_10_KHZ));
    localparam logic [DIV_W-1:0] HALF_RMII_10 =
        DIV_W'(REF_CLK_KHZ / (2 * RMII_10_KHZ));

    // Stream word: nibble plus end-of-frame flag
    localparam int          NIB_W    = 4;
    localparam int          WORD_W   = NIB_W + 1;
    localparam int          LAST_BIT = NIB_W;
    localparam logic [NIB_W-1:0] TXD_IDLE = 4'h0;

    // Divider half period for a mode and speed
    function automatic logic [DIV_W-1:0] half_sel(input link_mode_t m,
                                                  input logic fast);
        if (m == MODE_RMII)
            half_sel = HALF_RMII_10;
        else
            half_sel = fast ? HALF_MII_100 : HALF_MII_10;
    endfunction : half_sel

    // True where every link clock edge is a transmit edge
    function automatic logic tick_always(input link_mode_t m,
                                         input logic fast);
        tick_always = (m == MODE_MII_DTE) || ((m == MODE_RMII) && fast);
    endfunction : tick_always

endpackage : mii_tx_pkg

/* File: design/clk_div.sv */
/*
 * Clock divider producing a square clock level and a pulse that marks
 * the edge at which the level rises. Assumes a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_div
    import mii_tx_pkg::*;
#(
    parameter int W = DIV_W
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] half,
    input  wire logic         run,
    output logic              clk_o,
    output logic              rise
);

    generate
        if (W < 1)
        begin : g_bad_w
            $error("clk_div: W must be at least 1");
        end
    endgenerate

    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic         lvl;
    } div_t;

    div_t         s_r;
    div_t         s_nxt;
    logic [W:0]   cnt_p1;
    logic         wrap;

    // Half period ends when the count reaches the half value
    assign cnt_p1 = {1'b0, s_r.cnt} + {{W{1'b0}}, 1'b1};
    assign wrap   = cnt_p1 >= {1'b0, half};
    assign rise   = run && wrap && !s_r.lvl;
    assign clk_o  = s_r.lvl;

    // Next state of the divider
    always_comb
    begin
        s_nxt = s_r;
        if (!run)
        begin
            s_nxt = '0;
        end
        else if (wrap)
        begin
            s_nxt.cnt = '0;
            s_nxt.lvl = ~s_r.lvl;
        end
        else
        begin
            s_nxt.cnt = cnt_p1[W-1:0];
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule : clk_div
`default_nettype wire

/* File: design/two_entry_buf.sv */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module two_entry_buf
    import mii_tx_pkg::*;
#(
    parameter int W = WORD_W
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    generate
        if (W < 1)
        begin : g_bad_w
            $error("two_entry_buf: W must be at least 1");
        end
    endgenerate

    typedef struct packed
    {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } buf_t;

    buf_t s_r;
    buf_t s_nxt;
    logic push;
    logic pop;

    // Handshakes and head word
    assign in_ready  = s_r.cnt != 2'h2;
    assign out_valid = s_r.cnt != 2'h0;
    assign out_data  = s_r.mem[s_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = ~s_r.wp;
        end
        if (pop)
            s_nxt.rp = ~s_r.rp;
        if (push && !pop)
            s_nxt.cnt = s_r.cnt + 2'h1;
        else if (pop && !push)
            s_nxt.cnt = s_r.cnt - 2'h1;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule : two_entry_buf
`default_nettype wire

/* File: design/mii_rmii_tx_clocking.sv */
/*
 * Transmit clocking and enable logic for one MAC port facing a PHY over
 * MII or RMII, plus a reference clock output divided from mclk.
 * Assumes link_clk is REF_CLK in RMII and MII-DCE, and the PHY's TX_CLK
 * in MII-DTE, selected by the board; mode is changed only while idle.
 */
// What this block does
// - In RMII every transmit signal is driven on the REF_CLK edge.
// - In MII-DCE the outgoing TX_CLK and RX_CLK come from REF_CLK.
// - A derived reference clock is produced by dividing the system clock.
// - TX_CLK is 25 MHz at 100 Mbps and 2.5 MHz at 10 Mbps.
// - TX_CLK is an input from the PHY in DTE and a driven output in DCE.
// - TX_EN is high exactly while valid nibbles are on TXD.
// - TX_EN changes only with the rising edge of TX_CLK in MII.
// - TX_EN rises with the first preamble nibble of each frame.
// - TX_EN drops between frames, before the next frame's first nibble.
// - TXD bit 0 carries the least significant bit of each nibble.
// - In RMII TX_EN qualifies the two-bit data, timed by REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module mii_rmii_tx_clocking
    import mii_tx_pkg::*;
#(
    parameter int unsigned REFO_KHZ = REFO_KHZ_DFLT
)
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [1:0]       mode,
    input  wire logic             speed_100,
    input  wire logic [NIB_W-1:0] tx_data,
    input  wire logic             tx_valid,
    input  wire logic             tx_last,
    output logic                  tx_ready,
    output logic                  tx_underrun,
    output logic                  derived_reference_clock_out,
    input  wire logic             link_clk,
    output logic                  tx_clk_o,
    output logic                  tx_clk_oe,
    output logic                  rx_clk_o,
    output logic                  rx_clk_oe,
    output logic [NIB_W-1:0]      txd,
    output logic                  tx_en
);

    ///////////////////////////////////////////////////////////////////////
    // Parameter checks

    localparam int unsigned REFO_HALF_INT =
        MCLK_KHZ / (2 * ((REFO_KHZ == 0) ? 1 : REFO_KHZ));
    localparam logic [DIV_W-1:0] REFO_HALF = DIV_W'(REFO_HALF_INT);

    generate
        if (REFO_HALF_INT < 1 || REFO_HALF_INT >= (1 << DIV_W))
        begin : g_bad_refo
            $error("REFO_KHZ gives a divide ratio out of range");
        end
    endgenerate

    ///////////////////////////////////////////////////////////////////////
    // System clock domain state

    typedef struct packed
    {
        logic              req;
        logic [WORD_W-1:0] xdata;
        logic              ack_m;
        logic              ack_s;
        logic              und_m;
        logic              und_s;
        logic              und_d;
        logic              und_p;
    } sys_t;

    // Link clock domain state
    typedef struct packed
    {
        logic              rst_m;
        logic              rst_s;
        logic [1:0]        mode_m;
        logic [1:0]        mode_s;
        logic              spd_m;
        logic              spd_s;
        logic              req_m;
        logic              req_s;
        logic              ack;
        logic [WORD_W-1:0] hold;
        logic              hold_v;
        tx_state_t         state;
        logic              phase;
        logic              last;
        logic [NIB_W-1:0]  txd;
        logic              tx_en;
        logic              und_t;
    } lnk_t;

    sys_t              s_r;
    sys_t              s_nxt;
    lnk_t              l_r;
    lnk_t              l_nxt;

    logic [WORD_W-1:0] buf_data;
    logic              buf_valid;
    logic              buf_ready;
    logic              busy;

    link_mode_t        lmode;
    logic              div_run;
    logic              div_lvl;
    logic              div_rise;
    logic              tick;

    ///////////////////////////////////////////////////////////////////////
    // Input buffer: a stall of the crossing holds words here

    two_entry_buf #(.W(WORD_W)) u_inbuf
    (
        .clk       (mclk),
        .rst       (rst),
        .in_data   ({tx_last, tx_data}),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    // Derived reference clock from mclk
    clk_div #(.W(DIV_W)) u_refo_div
    (
        .clk   (mclk),
        .rst   (rst),
        .half  (REFO_HALF),
        .run   (1'b1),
        .clk_o (derived_reference_clock_out),
        .rise  ()
    );

    ///////////////////////////////////////////////////////////////////////
    // System side of the word handshake

    assign busy        = s_r.req != s_r.ack_s;
    assign buf_ready   = !busy;
    assign tx_underrun = s_r.und_p;

    // Launch a word when the previous one was acknowledged
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.ack_m = l_r.ack;
        s_nxt.ack_s = s_r.ack_m;
        s_nxt.und_m = l_r.und_t;
        s_nxt.und_s = s_r.und_m;
        s_nxt.und_d = s_r.und_s;
        s_nxt.und_p = s_r.und_s ^ s_r.und_d;
        if (buf_valid && !busy)
        begin
            s_nxt.xdata = buf_data;
            s_nxt.req   = ~s_r.req;
        end
    end

    // System domain register
    always_ff @(posedge mclk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    ///////////////////////////////////////////////////////////////////////
    // Link clock generation

    assign lmode   = link_mode_t'(l_r.mode_s);
    // Divider stops in DTE where the PHY owns TX_CLK
    assign div_run = !tick_always(lmode, l_r.spd_s);
    // Transmit edges: every link edge, or each divided rising edge
    assign tick    = tick_always(lmode, l_r.spd_s) || div_rise;

    clk_div #(.W(DIV_W)) u_tx_div
    (
        .clk   (link_clk),
        .rst   (l_r.rst_s),
        .half  (half_sel(lmode, l_r.spd_s)),
        .run   (div_run),
        .clk_o (div_lvl),
        .rise  (div_rise)
    );

    // Pin drive; TX_CLK and RX_CLK driven only in DCE
    assign tx_clk_o  = div_lvl;
    assign rx_clk_o  = div_lvl;
    assign tx_clk_oe = l_r.mode_s == MODE_MII_DCE;
    assign rx_clk_oe = l_r.mode_s == MODE_MII_DCE;
    assign txd       = l_r.txd;
    assign tx_en     = l_r.tx_en;

    ///////////////////////////////////////////////////////////////////////
    // Link side sequencer

    always_comb
    begin
        logic emit;
        emit         = 1'b0;
        l_nxt        = l_r;
        // Synchronisers for reset, config and request
        l_nxt.rst_m  = rst;
        l_nxt.rst_s  = l_r.rst_m;
        l_nxt.mode_m = mode;
        l_nxt.mode_s = l_r.mode_m;
        l_nxt.spd_m  = speed_100;
        l_nxt.spd_s  = l_r.spd_m;
        l_nxt.req_m  = s_r.req;
        l_nxt.req_s  = l_r.req_m;

        // Pin changes happen on a transmit edge only, or on any link edge under local reset
        if (tick)
        begin
            case (l_r.state)
                ST_IDLE:
                begin
                    l_nxt.tx_en = 1'b0;
                    l_nxt.txd   = TXD_IDLE;
                    if (l_r.hold_v)
                    begin
                        // First word is the first preamble nibble
                        l_nxt.state = ST_SEND;
                        l_nxt.tx_en = 1'b1;
                        emit        = 1'b1;
                    end
                end
                ST_SEND:
                begin
                    if (l_r.last && !l_r.phase)
                    begin
                        // Frame over; low for at least one edge
                        l_nxt.state = ST_IDLE;
                        l_nxt.last  = 1'b0;
                        l_nxt.tx_en = 1'b0;
                        l_nxt.txd   = TXD_IDLE;
                    end
                    else if (l_r.hold_v)
                    begin
                        emit = 1'b1;
                    end
                    else
                    begin
                        // Underrun: no invalid nibble is qualified
                        l_nxt.state = ST_DRAIN;
                        l_nxt.tx_en = 1'b0;
                        l_nxt.txd   = TXD_IDLE;
                        l_nxt.und_t = ~l_r.und_t;
                    end
                end
                ST_DRAIN:
                begin
                    // Discard the rest of a broken frame
                    l_nxt.tx_en = 1'b0;
                    l_nxt.txd   = TXD_IDLE;
                    if (l_r.hold_v)
                    begin
                        l_nxt.hold_v = 1'b0;
                        if (l_r.hold[LAST_BIT])
                            l_nxt.state = ST_IDLE;
                    end
                end
                default:
                begin
                    l_nxt.state = ST_IDLE;
                    l_nxt.tx_en = 1'b0;
                    l_nxt.txd   = TXD_IDLE;
                end
            endcase
        end

        // Present the held nibble, low bits first
        if (emit)
        begin
            if (l_r.mode_s == MODE_RMII)
            begin
                // Two dibits per nibble on TXD[1:0]
                if (!l_r.phase)
                begin
                    l_nxt.txd   = {2'b00, l_r.hold[1:0]};
                    l_nxt.phase = 1'b1;
                end
                else
                begin
                    l_nxt.txd    = {2'b00, l_r.hold[3:2]};
                    l_nxt.phase  = 1'b0;
                    l_nxt.hold_v = 1'b0;
                    l_nxt.last   = l_r.hold[LAST_BIT];
                end
            end
            else
            begin
                l_nxt.txd    = l_r.hold[NIB_W-1:0];
                l_nxt.hold_v = 1'b0;
                l_nxt.last   = l_r.hold[LAST_BIT];
            end
        end

        // Capture a new word while the holding slot is empty
        if (!l_r.hold_v && (l_r.req_s != l_r.ack))
        begin
            l_nxt.hold   = s_r.xdata;
            l_nxt.hold_v = 1'b1;
            l_nxt.ack    = l_r.req_s;
        end

        // Local reset keeps the reset synchroniser running
        if (l_r.rst_s)
        begin
            l_nxt.ack    = 1'b0;
            l_nxt.hold_v = 1'b0;
            l_nxt.state  = ST_IDLE;
            l_nxt.phase  = 1'b0;
            l_nxt.last   = 1'b0;
            l_nxt.txd    = TXD_IDLE;
            l_nxt.tx_en  = 1'b0;
            l_nxt.und_t  = 1'b0;
        end
    end

    // Link domain register
    always_ff @(posedge link_clk)
    begin
        l_r <= l_nxt;
    end

endmodule : mii_rmii_tx_clocking
`default_nettype wire

/* File: verif/tx_clk_props.sv */
/*
 * Port checks for the transmit clocking block, bound to its top module.
 * Assumes link_clk runs while rst is applied.
 */
`timescale 1ns/1ps
`default_nettype none
module tx_clk_props
    import mii_tx_pkg::*;
#(
    parameter int unsigned REFO_KHZ = REFO_KHZ_DFLT
)
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [1:0] mode,
    input wire logic       speed_100,
    input wire logic       tx_underrun,
    input wire logic       derived_reference_clock_out,
    input wire logic       link_clk,
    input wire logic       tx_clk_o,
    input wire logic       tx_clk_oe,
    input wire logic       rx_clk_oe,
    input wire logic [3:0] txd,
    input wire logic       tx_en
);
    localparam int RH = MCLK_KHZ / (2 * REFO_KHZ);
    logic       d_r;
    logic       seen_r;
    logic [7:0] cnt_r;
    logic [3:0] lsh_r;
    wire        lrst;
    wire        dce;
    wire        ticked;
    ////////////////////////////////////////////////////////////////////////
    // Cycles since the derived clock last changed
    always_ff @(posedge mclk)
    begin
        d_r <= derived_reference_clock_out;
        if (rst)
        begin
            seen_r <= 1'b0;
            cnt_r  <= 8'h00;
        end
        else if (derived_reference_clock_out != d_r)
        begin
            seen_r <= 1'b1;
            cnt_r  <= 8'h00;
        end
        else
            cnt_r <= cnt_r + 8'h01;
    end
    // Stretched reset for the link domain
    always_ff @(posedge link_clk)
        lsh_r <= {lsh_r[2:0], rst};
    assign lrst   = rst | (|lsh_r);
    assign dce    = (mode == MODE_MII_DCE);
    assign ticked = dce || (mode == MODE_RMII && !speed_100);
    ////////////////////////////////////////////////////////////////////////
    a_refo_half: assert property (@(posedge mclk) disable iff (rst)
        (seen_r && derived_reference_clock_out != d_r) |->
        cnt_r == 8'(RH - 1)) else $error("derived clock half period wrong");
    a_refo_runs: assert property (@(posedge mclk) disable iff (rst)
        cnt_r <= 8'(RH + 2)) else $error("derived clock stopped");
    a_oe_dce_only: assert property (@(posedge link_clk) disable iff (lrst)
        tx_clk_oe == dce && rx_clk_oe == dce)
        else $error("clock output enable wrong for mode");
    a_dce10_half: assert property (@(posedge link_clk) disable iff (lrst)
        ($rose(tx_clk_o) && dce && !speed_100) |=>
        tx_clk_o [*8] ##1 tx_clk_o ##1 !tx_clk_o)
        else $error("slow transmit clock half period wrong");
    a_dce100_half: assert property (@(posedge link_clk) disable iff (lrst)
        ($rose(tx_clk_o) && dce && speed_100) |=>
        !tx_clk_o ##1 tx_clk_o) else $error("fast transmit clock wrong");
    a_en_on_rise: assert property (@(posedge link_clk) disable iff (lrst)
        (ticked && $changed(tx_en)) |-> $rose(tx_clk_o))
        else $error("enable changed off the clock rise");
    a_txd_on_rise: assert property (@(posedge link_clk) disable iff (lrst)
        (ticked && $changed(txd)) |-> $rose(tx_clk_o))
        else $error("data changed off the clock rise");
    a_txd_idle: assert property (@(posedge link_clk) disable iff (lrst)
        !tx_en |-> txd == TXD_IDLE)
        else $error("data not idle while enable low");
    a_rmii_upper: assert property (@(posedge link_clk) disable iff (lrst)
        mode == MODE_RMII |-> txd[3:2] == 2'h0)
        else $error("upper data bits driven in reduced mode");
    a_underrun_one: assert property (@(posedge mclk) disable iff (rst)
        tx_underrun |=> !tx_underrun)
        else $error("underrun pulse too long");
endmodule : tx_clk_props

bind mii_rmii_tx_clocking tx_clk_props #(.REFO_KHZ(REFO_KHZ)) u_props (
    .mclk                        (mclk),
    .rst                         (rst),
    .mode                        (mode),
    .speed_100                   (speed_100),
    .tx_underrun                 (tx_underrun),
    .derived_reference_clock_out (derived_reference_clock_out),
    .link_clk                    (link_clk),
    .tx_clk_o                    (tx_clk_o),
    .tx_clk_oe                   (tx_clk_oe),
    .rx_clk_oe                   (rx_clk_oe),
    .txd                         (txd),
    .tx_en                       (tx_en)
);
`default_nettype wire

/* File: verif/phy_model.sv */
/*
 * PHY model: makes the link clock and collects transmitted nibbles.
 * Assumes sclk is the transmit clock the PHY samples on in this mode.
 */
`timescale 1ns/1ps
`default_nettype none
module phy_model
(
    input  wire logic        sclk,
    input  wire logic        rmii,
    input  wire logic        tx_en,
    input  wire logic [3:0]  txd,
    output var  logic        link_clk,
    output var  int          nib_cnt,
    output var  int          frames,
    output var  logic [31:0] got
);
    logic       prev_en;
    logic       half;
    logic [1:0] lo;
    ////////////////////////////////////////////////////////////////////////
    // Free running clock, stable well before reset release
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #16 link_clk = ~link_clk;
    end
    // Sample mid-period; assemble dibits low first in reduced mode
    initial
    begin
        nib_cnt = 0;
        frames  = 0;
        got     = 32'h0;
        prev_en = 1'b0;
        half    = 1'b0;
        lo      = 2'h0;
    end
    always @(negedge sclk)
    begin
        if (tx_en === 1'b1 && rmii && half)
        begin
            got = {txd[1:0], lo, got[31:4]};
            nib_cnt++;
        end
        else if (tx_en === 1'b1 && rmii)
            lo = txd[1:0];
        else if (tx_en === 1'b1)
        begin
            got = {txd, got[31:4]};
            nib_cnt++;
        end
        half = (tx_en === 1'b1 && rmii) ? !half : 1'b0;
        if (prev_en && tx_en !== 1'b1)
            frames++;
        prev_en = (tx_en === 1'b1);
    end
endmodule : phy_model
`default_nettype wire

/* File: verif/testbench.sv */
/*
 * Self-checking bench for the transmit clocking block with a PHY model.
 * Assumes the checker is bound to the block from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module testbench
    import mii_tx_pkg::*;
;
    logic        mclk, rst, speed_100, tx_valid, tx_last;
    logic [1:0]  mode;
    logic [3:0]  tx_data;
    logic        tx_ready, tx_underrun, refo, link_clk, tx_clk_o;
    logic        tx_clk_oe, rx_clk_o, rx_clk_oe, tx_en;
    logic [3:0]  txd;
    logic [31:0] got;
    int          nib_cnt, frames, err_total, comparisons;
    logic        full_seen, urun_seen;
    wire         sclk;
    wire         rmii;
    ////////////////////////////////////////////////////////////////////////
    assign sclk = (mode == MODE_MII_DTE) ? link_clk : tx_clk_o;
    assign rmii = (mode == MODE_RMII);
    mii_rmii_tx_clocking #(.REFO_KHZ(5000)) uut (
        .mclk(mclk), .rst(rst), .mode(mode), .speed_100(speed_100),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_underrun(tx_underrun),
        .derived_reference_clock_out(refo), .link_clk(link_clk),
        .tx_clk_o(tx_clk_o), .tx_clk_oe(tx_clk_oe), .rx_clk_o(rx_clk_o),
        .rx_clk_oe(rx_clk_oe), .txd(txd), .tx_en(tx_en));
    phy_model phy (.sclk(sclk), .rmii(rmii), .tx_en(tx_en), .txd(txd),
        .link_clk(link_clk), .nib_cnt(nib_cnt), .frames(frames),
        .got(got));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Underrun pulses last one cycle, so latch them
    always @(posedge mclk)
        if (tx_underrun === 1'b1)
            urun_seen <= 1'b1;
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task do_reset(input logic [1:0] m, input logic s);
        rst = 1'b1;
        mode = m;
        speed_100 = s;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : do_reset
    // Offer one word and hold it until taken
    task push(input logic [3:0] d, input logic l);
        int k;
        tx_data = d;
        tx_last = l;
        tx_valid = 1'b1;
        for (k = 0; tx_ready !== 1'b1; k++)
        begin
            full_seen = 1'b1;
            if (k > 2000)
            begin
                err_total++;
                $display("[ERR] tx_ready expected %h seen %h", 1'b1, tx_ready);
                report_and_stop();
            end
            @(negedge mclk);
        end
        @(negedge mclk);
    endtask : push
    task send_frame(input logic [3:0] base);
        for (int i = 0; i < 8; i++)
            push(base + 4'(i), i == 7);
        tx_valid = 1'b0;
    endtask : send_frame
    task wait_done(input int n);
        for (int k = 0; frames < n || urun_seen !== 1'b1 && n < 0; k++)
        begin
            if (k > 5000)
            begin
                err_total++;
                $display("[ERR] frames expected %0d seen %0d", n, frames);
                report_and_stop();
            end
            @(negedge mclk);
        end
    endtask : wait_done
    ////////////////////////////////////////////////////////////////////////
    // Slow DCE transmit clock, back-to-back frames through a full buffer
    task t_dce10;
        int f0, n0;
        do_reset(MODE_MII_DCE, 1'b0);
        f0 = frames;
        n0 = nib_cnt;
        full_seen = 1'b0;
        urun_seen = 1'b0;
        send_frame(4'h1);
        send_frame(4'h9);
        wait_done(f0 + 2);
        `CHK("frames", f0 + 2, frames)
        `CHK("nibbles", n0 + 16, nib_cnt)
        `CHK("nibble order", 32'h0FEDCBA9, got)
        `CHK("buffer full", 1'b1, full_seen)
        `CHK("underrun", 1'b0, urun_seen)
        `CHK("tx_clk_oe", 1'b1, tx_clk_oe)
        `CHK("rx_clk_oe", 1'b1, rx_clk_oe)
        `CHK("rx_clk_o", tx_clk_o, rx_clk_o)
    endtask : t_dce10
    // Reduced mode, dibits low first
    task t_rmii10;
        int f0;
        do_reset(MODE_RMII, 1'b0);
        f0 = frames;
        send_frame(4'h1);
        wait_done(f0 + 1);
        `CHK("dibit order", 32'h87654321, got)
        `CHK("tx_clk_oe", 1'b0, tx_clk_oe)
    endtask : t_rmii10
    // Link faster than the crossing: frame is cut short
    task t_fast(input logic [1:0] m, input logic s);
        do_reset(m, s);
        urun_seen = 1'b0;
        send_frame(4'h3);
        wait_done(-1);
        `CHK("underrun", 1'b1, urun_seen)
        `CHK("tx_clk_oe", m == MODE_MII_DCE, tx_clk_oe)
    endtask : t_fast
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        mode = MODE_MII_DCE;
        speed_100 = 1'b0;
        tx_data = 4'h0;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        err_total = 0;
        comparisons = 0;
        full_seen = 1'b0;
        urun_seen = 1'b0;
        t_dce10();
        t_rmii10();
        t_fast(MODE_MII_DTE, 1'b1);
        t_fast(MODE_MII_DCE, 1'b1);
        t_fast(MODE_RMII, 1'b1);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
